// *** spf_framer.sv ***
`default_nettype none
module spf_framer #(
  parameter int unsigned FRAME_TICKS = spf_pkg::FRAME_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          state_reset,
  input  wire logic [spf_pkg::WORD_W-1:0]    enc_sample_word,
  output var  logic [spf_pkg::SAMPLE_W-1:0]  enc_sample,
  input  wire logic [spf_pkg::SAMPLE_W-1:0]  dec_sample,
  output var  logic [spf_pkg::WORD_W-1:0]    dec_sample_word,
  input  wire logic                          enc_param_valid,
  input  wire logic [spf_pkg::WORD_W-1:0]    enc_param_code,
  output var  logic                          enc_param_ready,
  output var  logic                          cod_out_valid,
  output var  logic [spf_pkg::WORD_W-1:0]    cod_out_data,
  output var  logic                          cod_out_last,
  input  wire logic                          cod_out_ready,
  input  wire logic                          cod_in_valid,
  input  wire logic [spf_pkg::WORD_W-1:0]    cod_in_data,
  output var  logic                          cod_in_ready,
  output var  logic                          code_valid,
  output var  logic [spf_pkg::CODE_W-1:0]    code,
  output var  logic [spf_pkg::IDX_W-1:0]     code_index,
  output var  logic                          frame_tick,
  output var  logic                          frame_overrun
);
  import spf_pkg::*;

  // ----------------------------------------------------------------
  // Field width by word position
  // ----------------------------------------------------------------
  function automatic logic [FW_W-1:0] field_width(input logic [IDX_W-1:0] idx);
    logic [IDX_W-1:0] rel;
    logic [4:0]       pos;
    rel = idx - LAR_WORDS;
    pos = 5'(rel % 7'(SUB_WORDS));
    if (idx < 7'h02)
      field_width = LAR12_W;
    else if (idx < 7'h04)
      field_width = LAR34_W;
    else if (idx < 7'h06)
      field_width = LAR56_W;
    else if (idx < LAR_WORDS)
      field_width = LAR78_W;
    else if (pos == SUB_LAG_POS)
      field_width = LAG_W;
    else if (pos == SUB_GAIN_POS)
      field_width = GAIN_W;
    else if (pos == SUB_GRID_POS)
      field_width = GRID_W;
    else if (pos == SUB_AMP_POS)
      field_width = AMP_W;
    else
      field_width = PULSE_W;
  endfunction

  // Keeps the low bits of a word and clears the rest, so that any stray upper bits never reach the far side
  function automatic logic [WORD_W-1:0] right_justify(input logic [WORD_W-1:0] w,
                                                      input logic [FW_W-1:0]   fw);
    logic [WORD_W-1:0] mask;
    mask = ~({WORD_W{1'b1}} << fw);
    right_justify = w & mask;
  endfunction

  // ----------------------------------------------------------------
  // Sample words
  // ----------------------------------------------------------------
  wire [SAMPLE_W-1:0] next_enc_sample      = enc_sample_word[WORD_W-1:SAMPLE_PAD];
  wire [WORD_W-1:0]   next_dec_sample_word = {dec_sample, {SAMPLE_PAD{1'b0}}};

  // Sample registers ignore state_reset, so a frame abort never disturbs the audio path
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enc_sample <= '0;
    end else begin
      enc_sample <= next_enc_sample;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dec_sample_word <= '0;
    end else begin
      dec_sample_word <= next_dec_sample_word;
    end
  end

  // ----------------------------------------------------------------
  // Encoder side: packing into the two-entry buffer
  // ----------------------------------------------------------------
  logic [IDX_W-1:0]  enc_idx;
  logic [WORD_W:0]   buf_mem [0:1];
  logic [1:0]        buf_count;
  wire               push         = enc_param_valid & enc_param_ready;
  wire               pop          = cod_out_valid & cod_out_ready;
  wire               enc_last     = (enc_idx == LAST_IDX);
  wire [WORD_W-1:0]  enc_word     = right_justify(enc_param_code, field_width(enc_idx));
  wire [1:0]         next_count   = buf_count + {1'b0, push} - {1'b0, pop};
  wire [1:0]         wr_slot      = buf_count - {1'b0, pop};
  wire [IDX_W-1:0]   next_enc_idx = enc_last ? '0 : enc_idx + 7'h01;
  // Full and empty are judged on the count after this edge, so ready and valid stay registered
  wire               next_full    = (next_count == 2'h2);
  wire               next_empty   = (next_count == 2'h0);

  always_ff @(posedge clk) begin
    if (!rst_n || state_reset) begin
      enc_idx <= '0;
    end else if (push) begin
      enc_idx <= next_enc_idx;
    end
  end

  // A stall on the output side backs up into enc_param_ready, so no word is dropped
  always_ff @(posedge clk) begin
    if (!rst_n || state_reset) begin
      buf_count       <= '0;
      enc_param_ready <= 1'b0;
      cod_out_valid   <= 1'b0;
    end else begin
      buf_count       <= next_count;
      enc_param_ready <= !next_full;
      cod_out_valid   <= !next_empty;
    end
  end

  // Entry 0 is always the head; a pop shifts entry 1 down, and a push in the same cycle (only with one entry held) lands in entry 0
  always_ff @(posedge clk) begin
    if (!rst_n || state_reset) begin
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
    end else begin
      if (pop)
        buf_mem[0] <= buf_mem[1];
      if (push)
        buf_mem[wr_slot[0]] <= {enc_last, enc_word};
    end
  end

  assign cod_out_data = buf_mem[0][WORD_W-1:0];
  assign cod_out_last = buf_mem[0][WORD_W];

  // ----------------------------------------------------------------
  // Decoder side: unpacking, never refusing a code
  // ----------------------------------------------------------------
  logic [IDX_W-1:0]  dec_idx;
  wire               take         = cod_in_valid & cod_in_ready;
  wire               dec_last     = (dec_idx == LAST_IDX);
  wire [WORD_W-1:0]  dec_word     = right_justify(cod_in_data, field_width(dec_idx));
  wire [IDX_W-1:0]   next_dec_idx = dec_last ? '0 : dec_idx + 7'h01;
  wire [CODE_W-1:0]  dec_code     = dec_word[CODE_W-1:0];

  // Nothing on this side may refuse a word, so ready only drops for a reset
  always_ff @(posedge clk) begin
    if (!rst_n || state_reset) begin
      dec_idx      <= '0;
      cod_in_ready <= 1'b0;
      code_valid   <= 1'b0;
    end else begin
      cod_in_ready <= 1'b1;
      code_valid   <= take;
      if (take)
        dec_idx <= next_dec_idx;
    end
  end

  // The code field is as wide as the lag, the widest word, so lags above 120 pass as they are
  always_ff @(posedge clk) begin
    if (!rst_n || state_reset) begin
      code       <= '0;
      code_index <= '0;
    end else if (take) begin
      code       <= dec_code;
      code_index <= dec_idx;
    end
  end

  // ----------------------------------------------------------------
  // Frame interval
  // ----------------------------------------------------------------
  // A frame still half received at the interval boundary means the sender is too slow
  logic [TIMER_W-1:0] frame_timer;
  wire                timer_end  = (frame_timer == TIMER_W'(FRAME_TICKS - 1));
  wire [TIMER_W-1:0]  next_timer = timer_end ? '0 : frame_timer + TIMER_W'(1);
  wire                mid_frame  = (dec_idx != '0);

  always_ff @(posedge clk) begin
    if (!rst_n || state_reset) begin
      frame_timer <= '0;
      frame_tick  <= 1'b0;
    end else begin
      frame_timer <= next_timer;
      frame_tick  <= timer_end;
    end
  end

  // Sticky until a reset, so a slow watcher still learns that an interval was missed
  always_ff @(posedge clk) begin
    if (!rst_n || state_reset) begin
      frame_overrun <= 1'b0;
    end else if (timer_end && mid_frame) begin
      frame_overrun <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// *** spf_framer_asserts.sv ***
`default_nettype none
module spf_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        state_reset,
  input wire logic [15:0] enc_sample_word,
  input wire logic [12:0] enc_sample,
  input wire logic [12:0] dec_sample,
  input wire logic [15:0] dec_sample_word,
  input wire logic        cod_in_valid,
  input wire logic [15:0] cod_in_data,
  input wire logic        cod_in_ready,
  input wire logic        code_valid,
  input wire logic [6:0]  code,
  input wire logic [6:0]  code_index,
  input wire logic        cod_out_valid,
  input wire logic        cod_out_ready,
  input wire logic [15:0] cod_out_data,
  input wire logic        frame_tick,
  input wire logic        frame_overrun
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n || state_reset);
  // Position inside a subframe; only meaningful from index 8 on
  wire [4:0] sub = 5'((code_index - 7'h08) % 7'h11);
  wire       in_sub = code_index >= 7'h08;
  a_enc_sample: assert property ($past(rst_n) |->
    enc_sample == $past(enc_sample_word[15:3])) else $error("enc");
  a_dec_sample: assert property ($past(rst_n) |->
    dec_sample_word == {$past(dec_sample), 3'h0}) else $error("dec");
  a_code_pulse: assert property ($past(rst_n && !state_reset) |->
    code_valid == $past(cod_in_valid && cod_in_ready)) else $error("pulse");
  a_in_ready: assert property ($past(rst_n && !state_reset) |-> cod_in_ready) else $error("in ready");
  a_lar_width: assert property (code_valid && code_index < 7'h02 |->
    code == {1'b0, $past(cod_in_data[5:0])}) else $error("lar");
  a_lag_pass: assert property (code_valid && in_sub && sub == 5'h00 |->
    code == $past(cod_in_data[6:0])) else $error("lag");
  a_pulse_width: assert property (code_valid && in_sub && sub > 5'h03 |->
    code == {4'h0, $past(cod_in_data[2:0])}) else $error("pulse code");
  a_out_hold: assert property (cod_out_valid && !cod_out_ready |=>
    cod_out_valid && $stable(cod_out_data)) else $error("hold");
  a_tick_gap: assert property (frame_tick |=> !frame_tick [*8]) else $error("tick");
  a_overrun_sticky: assert property (frame_overrun |=> frame_overrun) else $error("overrun");
endmodule
bind spf_framer spf_chk i_chk (
  .clk             (clk),
  .rst_n           (rst_n),
  .state_reset     (state_reset),
  .enc_sample_word (enc_sample_word),
  .enc_sample      (enc_sample),
  .dec_sample      (dec_sample),
  .dec_sample_word (dec_sample_word),
  .cod_in_valid    (cod_in_valid),
  .cod_in_data     (cod_in_data),
  .cod_in_ready    (cod_in_ready),
  .code_valid      (code_valid),
  .code            (code),
  .code_index      (code_index),
  .cod_out_valid   (cod_out_valid),
  .cod_out_ready   (cod_out_ready),
  .cod_out_data    (cod_out_data),
  .frame_tick      (frame_tick),
  .frame_overrun   (frame_overrun)
);
`default_nettype wire

// *** spf_framer_tb.sv ***
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fails++; $display("[ERR] %s %h %h", n, e, s); end end
module spf_framer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_n = 1'b0, state_reset = 1'b0, enc_param_valid = 1'b0, cod_in_valid = 1'b0;
  logic [15:0] enc_sample_word = '0, enc_param_code = '0, cod_in_data = '0, sw = '0, ev, dec_sample_word, cod_out_data;
  logic [12:0] dec_sample = '0, sd = '0, enc_sample;
  logic        enc_param_ready, cod_out_valid, cod_out_last, cod_out_ready, cod_in_ready, code_valid;
  logic        frame_tick, frame_overrun, took = 1'b0, pv = 1'b0, ovx = 1'b0;
  logic [6:0]  code, code_index, pc, pi;
  logic [15:0] eq[$];
  int          fails = 0, total_checks = 0, ei = 0, oi = 0, di = 0, cyc = 0, n;
  localparam int TICKS = 200;
  spf_framer #(.FRAME_TICKS(TICKS)) i_spf_framer (
    .clk             (clk),
    .rst_n           (rst_n),
    .state_reset     (state_reset),
    .enc_sample_word (enc_sample_word),
    .enc_sample      (enc_sample),
    .dec_sample      (dec_sample),
    .dec_sample_word (dec_sample_word),
    .enc_param_valid (enc_param_valid),
    .enc_param_code  (enc_param_code),
    .enc_param_ready (enc_param_ready),
    .cod_out_valid   (cod_out_valid),
    .cod_out_data    (cod_out_data),
    .cod_out_last    (cod_out_last),
    .cod_out_ready   (cod_out_ready),
    .cod_in_valid    (cod_in_valid),
    .cod_in_data     (cod_in_data),
    .cod_in_ready    (cod_in_ready),
    .code_valid      (code_valid),
    .code            (code),
    .code_index      (code_index),
    .frame_tick      (frame_tick),
    .frame_overrun   (frame_overrun)
  );
  spf_sink i_spf_sink (.clk(clk), .rst_n(rst_n), .ready(cod_out_ready));
  always #2.5 clk = ~clk;
  function automatic logic [15:0] msk(input int i, input logic [15:0] d);
    int j, w;
    j = (i - 8) % 17;
    w = i < 8 ? 6 - i / 2 : j == 0 ? 7 : j < 3 ? 2 : j == 3 ? 6 : 3;
    return d & 16'((1 << w) - 1);
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #10us;
    fails++;
    close_out;
  end
  always @(posedge clk) begin
    if (!rst_n || state_reset) begin
      eq.delete();
      {ei, oi, di, cyc, took, pv, ovx} = '0;
    end else begin
      cyc++;
      `CHK("frame_tick", cyc > 1 && (cyc - 1) % TICKS == 0, frame_tick)
      `CHK("overrun", ovx, frame_overrun)
      // An interval that ends with a decoder frame half taken sets the sticky flag
      if (cyc % TICKS == 0 && di != 0) ovx = 1'b1;
      if (cyc > 1) begin
        `CHK("in_ready", eq.size() != 2, enc_param_ready)
        `CHK("out_valid", eq.size() != 0, cod_out_valid)
      end
      if (cod_out_valid && cod_out_ready) begin
        ev = eq.pop_front();
        `CHK("out_data", ev, cod_out_data)
        `CHK("out_last", oi == spf_pkg::LAST_IDX, cod_out_last)
        oi = (oi + 1) % 76;
      end
      `CHK("code_valid", pv, code_valid)
      if (pv) begin
        `CHK("code", pc, code)
        `CHK("code_index", pi, code_index)
      end
      pv = cod_in_valid && cod_in_ready;
      pc = 7'(msk(di, cod_in_data));
      pi = 7'(di);
      di = pv ? (di + 1) % 76 : di;
      took = enc_param_valid && enc_param_ready;
      if (took) eq.push_back(msk(ei, enc_param_code));
      ei = took ? (ei + 1) % 76 : ei;
    end
  end
  initial begin
    void'($urandom(32'h53b91530));
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    // No homing, so a state reset opens the run before the first frame
    state_reset = 1'b1;
    for (n = 0; n < 600; n++) begin
      @(negedge clk);
      `CHK("enc_sample", sw[15:3], enc_sample)
      `CHK("dec_word", {sd, 3'h0}, dec_sample_word)
      sw = 16'($urandom);
      sd = 13'($urandom);
      enc_sample_word = sw;
      dec_sample = sd;
      // Abort in mid-frame: indexes restart and the buffer is emptied
      state_reset = n == 300;
      if (!enc_param_valid || took) begin
        enc_param_valid = $urandom % 4 != 0;
        enc_param_code = 16'($urandom);
      end
      if (!cod_in_valid || pv) begin
        cod_in_valid = n < 160 || $urandom % 2;
        cod_in_data = 16'($urandom);
        // Lags below and above the range an encoder would send
        if (di == 8 || di == 25) cod_in_data[6:0] = di == 8 ? 7'h00 : 7'h7f;
      end
    end
    close_out;
  end
endmodule
`default_nettype wire

// *** spf_pkg.sv ***
`default_nettype none
package spf_pkg;
  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W         = 16;
  localparam int unsigned IDX_W          = 7;
  localparam int unsigned CODE_W         = 7;
  localparam int unsigned FW_W           = 3;
  localparam logic [6:0]  FRAME_WORDS    = 7'h4c;
  localparam logic [6:0]  LAST_IDX       = 7'h4b;
  localparam logic [6:0]  LAR_WORDS      = 7'h08;
  localparam logic [4:0]  SUB_WORDS      = 5'h11;
  localparam logic [4:0]  SUB_LAG_POS    = 5'h00;
  localparam logic [4:0]  SUB_GAIN_POS   = 5'h01;
  localparam logic [4:0]  SUB_GRID_POS   = 5'h02;
  localparam logic [4:0]  SUB_AMP_POS    = 5'h03;
  localparam logic [2:0]  LAR12_W        = 3'h6;
  localparam logic [2:0]  LAR34_W        = 3'h5;
  localparam logic [2:0]  LAR56_W        = 3'h4;
  localparam logic [2:0]  LAR78_W        = 3'h3;
  localparam logic [2:0]  LAG_W          = 3'h7;
  localparam logic [2:0]  GAIN_W         = 3'h2;
  localparam logic [2:0]  GRID_W         = 3'h2;
  localparam logic [2:0]  AMP_W          = 3'h6;
  localparam logic [2:0]  PULSE_W        = 3'h3;
  // ----------------------------------------------------------------
  // Sample layout
  // ----------------------------------------------------------------
  localparam int unsigned SAMPLE_W       = 13;
  localparam int unsigned SAMPLE_PAD     = 3;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 200000000;
  localparam int unsigned FRAME_MS       = 20;
  localparam int unsigned FRAME_CYCLES   = CLK_HZ / 1000 * FRAME_MS;
  localparam int unsigned TIMER_W        = 22;
endpackage
`default_nettype wire

// *** spf_sink.sv ***
`default_nettype none
module spf_sink (
  input  wire logic clk,
  input  wire logic rst_n,
  output var  logic ready = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Mostly stalled, so the two-entry buffer fills and has to refuse
  always @(negedge clk) ready <= rst_n && ($urandom % 4 == 0);
endmodule
`default_nettype wire

// *** spf_unused_none.sv ***
`default_nettype none
`default_nettype wire
